// >>> common/gos_dg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface gos_dg_if;
  import gos_pkg::*;
  logic    valid;
  logic    ready;
  gos_dg_t dg;
  modport src (output valid, output dg, input ready);
  modport snk (input valid, input dg, output ready);
endinterface
`default_nettype wire

// >>> common/gos_pkg.sv
// Behaviour
// R1: strobe falls on the output rate tick
// R2: strobe rises once datagram's last bit left
// R3: external trigger mode: strobe is sync only
// R4: enter init on power, reset, commands
// R5: init: settle, sync, send three identity datagrams
// R6: identity datagrams differ from measurement datagrams
// R7: after third identity datagram, enter normal unaided
// R8: normal mode resends identity datagram on request
// R9: sample at 2000/s; send per rate or trigger
// R10: keep sending whatever the status reports
// R11: start-up bit set fixed period, then cleared
// R12: start-up still samples and transmits normally
// R13: service exit to normal skips start-up
// R14: incremental angle: scaled sum since last send
// R15: average rate: mean since last send
// R16: integrated angle accumulates, wraps at four degrees
// R17: rate output: most recent internal sample
// R18: 24-bit two's complement, 2^-14 deg/s LSB
// R19: clear accumulators on every measurement send
// R20: trigger falling edge sends latest measurement
// R21: external reset low forces init mode
`default_nettype none
package gos_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS    = 40;
  localparam int SAMPLE_PERIOD_NS = 500000;
  localparam int TICK_CYC         = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SETTLE_TICKS     = 200;
  localparam int STARTUP_TICKS    = 2000;
  // ----------------------------------------
  // widths and scaling
  // ----------------------------------------
  localparam int AXES    = 3;
  localparam int RATE_W  = 24;
  localparam int SUM_W   = 36;
  localparam int DIV_W   = 12;
  localparam int TCNT_W  = 14;
  localparam int PCNT_W  = 16;
  localparam int REM_W   = 8;
  localparam int ANG_MUL = 8;
  localparam int ANG_DIV = 125;
  localparam int ID_LAST = 2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {OM_RATE, OM_INCR, OM_AVG, OM_INTEG} gos_omode_t;
  typedef enum logic [1:0] {DK_MEAS, DK_PART, DK_SERIAL, DK_CONFIG} gos_kind_t;
  typedef enum logic [1:0] {MD_INIT, MD_NORMAL, MD_SERVICE} gos_mode_t;
  typedef struct packed {
    gos_kind_t         kind;
    logic              startup;
    logic [RATE_W-1:0] x;
    logic [RATE_W-1:0] y;
    logic [RATE_W-1:0] z;
  } gos_dg_t;
endpackage
`default_nettype wire

// >>> rtl/gos_axis.sv
`timescale 1ns/100ps
`default_nettype none
module gos_axis
  import gos_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // control
  input  wire logic              tick,
  input  wire logic              clr,
  input  wire logic              integ_clr,
  input  wire gos_omode_t        omode,
  // sample in, value out
  input  wire logic [RATE_W-1:0] rate,
  output logic      [RATE_W-1:0] value
);
  typedef struct packed {
    logic signed [SUM_W-1:0] sum;
    logic        [DIV_W:0]   cnt;
    logic        [RATE_W-1:0] last;
    logic        [RATE_W-1:0] ang;
    logic signed [REM_W-1:0] rem;
  } gos_axis_st_t;

  gos_axis_st_t            s_r;
  gos_axis_st_t            s_nxt;
  logic signed [31:0]      step;
  logic signed [31:0]      quo;
  logic signed [31:0]      res;
  logic signed [SUM_W+3:0] incr;
  logic signed [SUM_W-1:0] avg;

  // ----------------------------------------
  // angle step kept exact: rate*8/125 with carried remainder
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    step = 32'($signed(rate)) * 32'(ANG_MUL) + 32'(s_r.rem);
    quo = step / 32'(ANG_DIV);
    res = step - quo * 32'(ANG_DIV);
    if (res < 0) begin
      quo = quo - 32'sd1;
      res = res + 32'(ANG_DIV);
    end
    if (clr) begin
      s_nxt.sum = '0; // R19
      s_nxt.cnt = '0;
    end
    if (tick) begin
      s_nxt.last = rate; // R17
      s_nxt.sum = s_nxt.sum + SUM_W'($signed(rate)); // R14 R15
      s_nxt.cnt = s_nxt.cnt + 1'b1;
      s_nxt.ang = s_r.ang + quo[RATE_W-1:0]; // R16
      s_nxt.rem = res[REM_W-1:0];
    end
    if (integ_clr) begin
      s_nxt.ang = '0;
      s_nxt.rem = '0;
    end
  end

  always_comb begin
    incr = ((SUM_W+4)'(s_r.sum) * (SUM_W+4)'(ANG_MUL)) / (SUM_W+4)'(ANG_DIV); // R14
    avg = '0;
    if (s_r.cnt != '0) begin
      avg = s_r.sum / $signed({1'b0, s_r.cnt}); // R15
    end
    case (omode)
      OM_RATE:  value = s_r.last; // R17 R18
      OM_INCR:  value = incr[RATE_W-1:0];
      OM_AVG:   value = avg[RATE_W-1:0];
      OM_INTEG: value = s_r.ang;
      default:  value = s_r.last;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  a_clear_window: assert property (@(posedge clk) disable iff (!rst_b) // R19
    clr && !tick |=> s_r.cnt == '0 && s_r.sum == '0)
    else $error("accumulator not cleared on send");
  a_rate_latest: assert property (@(posedge clk) disable iff (!rst_b) // R17
    tick && omode == OM_RATE ##1 omode == OM_RATE |-> value == $past(rate))
    else $error("rate output is not the latest sample");
endmodule
`default_nettype wire

// >>> rtl/gos_buf.sv
`timescale 1ns/100ps
`default_nettype none
module gos_buf
  import gos_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // datagram path
  gos_dg_if.snk     in_if,
  gos_dg_if.src     out_if
);
  typedef struct packed {
    logic    hv;
    logic    sv;
    gos_dg_t head;
    gos_dg_t spare;
  } gos_buf_st_t;

  gos_buf_st_t s_r;
  gos_buf_st_t s_nxt;

  // ----------------------------------------
  // two-entry skid: head drives out, spare absorbs a stall
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (out_if.ready && s_r.hv) begin
      if (s_r.sv) begin
        s_nxt.head = s_r.spare;
        s_nxt.sv = 1'b0;
      end else begin
        s_nxt.hv = 1'b0;
      end
    end
    if (in_if.valid && !s_r.sv) begin
      if (!s_nxt.hv) begin
        s_nxt.head = in_if.dg;
        s_nxt.hv = 1'b1;
      end else begin
        s_nxt.spare = in_if.dg;
        s_nxt.sv = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_if.ready  = !s_r.sv;
  assign out_if.valid = s_r.hv;
  assign out_if.dg    = s_r.head;

  a_full_holds: assert property (@(posedge clk) disable iff (!rst_b) // R10
    s_r.sv && !out_if.ready |=> s_r.sv && $stable(s_r.head))
    else $error("full buffer lost or changed a word");
endmodule
`default_nettype wire

// >>> rtl/gos_top.sv
`timescale 1ns/100ps
`default_nettype none
module gos_top
  import gos_pkg::*;
#(
  parameter int TICK_CYCLES     = TICK_CYC,
  parameter int SETTLE_TICKS_P  = SETTLE_TICKS,
  parameter int STARTUP_TICKS_P = STARTUP_TICKS
)
(
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST_B,
  // pins
  input  wire logic              EXTERNAL_RESET_LOW,
  input  wire logic              TRIGGER_INPUT,
  output logic                   VALIDITY_STROBE,
  // configuration
  input  wire logic              CFG_EXT_TRIG,
  input  wire logic [1:0]        CFG_OUT_MODE,
  input  wire logic [DIV_W-1:0]  CFG_SAMPLES_PER_TX,
  // commands
  input  wire logic              CMD_RESET,
  input  wire logic              CMD_ID_REQ,
  input  wire logic [1:0]        CMD_ID_KIND,
  input  wire logic              CMD_SVC_ENTER,
  input  wire logic              CMD_SVC_EXIT,
  input  wire logic              CMD_SVC_TO_INIT,
  // sensor samples
  input  wire logic [RATE_W-1:0] AXIS_RATE_X,
  input  wire logic [RATE_W-1:0] AXIS_RATE_Y,
  input  wire logic [RATE_W-1:0] AXIS_RATE_Z,
  // serial transmitter
  output logic                   DG_VALID,
  input  wire logic              DG_READY,
  output logic [1:0]             DG_KIND,
  output logic                   DG_STARTUP,
  output logic [RATE_W-1:0]      DG_X,
  output logic [RATE_W-1:0]      DG_Y,
  output logic [RATE_W-1:0]      DG_Z,
  input  wire logic              TX_DONE,
  // status
  output logic                   STATUS_STARTUP,
  output logic [1:0]             OP_MODE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    gos_mode_t         mode;
    logic              rst_s1;
    logic              rst_s2;
    logic              trg_s1;
    logic              trg_s2;
    logic              trg_d;
    logic [TCNT_W-1:0] tick_cnt;
    logic              tick;
    logic [DIV_W-1:0]  div_cnt;
    logic [PCNT_W-1:0] phase_cnt;
    logic              settled;
    logic [1:0]        id_idx;
    logic              id_wait;
    logic              startup;
    logic              id_pend;
    gos_kind_t         id_kind;
    logic              send_pend;
    logic [1:0]        out_cnt;
    logic              validity_strobe;
  } gos_top_st_t;

  localparam gos_top_st_t ST_RST = '{
    mode:      MD_INIT,
    rst_s1:    1'b0,
    rst_s2:    1'b0,
    trg_s1:    1'b1,
    trg_s2:    1'b1,
    trg_d:     1'b1,
    tick_cnt:  '0,
    tick:      1'b0,
    div_cnt:   '0,
    phase_cnt: '0,
    settled:   1'b0,
    id_idx:    2'h0,
    id_wait:   1'b0,
    startup:   1'b0,
    id_pend:   1'b0,
    id_kind:   DK_MEAS,
    send_pend: 1'b0,
    out_cnt:   2'h0,
    validity_strobe:       1'b1
  };

  gos_top_st_t       s_r;
  gos_top_st_t       s_nxt;
  gos_dg_t           push_dg;
  logic              push_v;
  logic              pushed;
  logic              done;
  logic              acc_clr;
  logic              integ_clr;
  logic              rate_tick;
  logic              trig_fall;
  logic              ext_sync;
  logic [DIV_W-1:0]  n_m1;
  logic [RATE_W-1:0] rate_a [AXES];
  logic [RATE_W-1:0] val_a  [AXES];

  gos_dg_if push_if ();
  gos_dg_if pop_if ();

  // ----------------------------------------
  // entry into init, shared by every cause except RST_B, which loads ST_RST
  // ----------------------------------------
  function automatic gos_top_st_t go_init(input gos_top_st_t s);
    gos_top_st_t t;
    t = s;
    t.mode = MD_INIT;
    t.settled = 1'b0;
    t.phase_cnt = '0;
    t.id_idx = 2'h0;
    t.id_wait = 1'b0;
    t.startup = 1'b0;
    t.id_pend = 1'b0;
    t.send_pend = 1'b0;
    t.tick_cnt = '0;
    t.div_cnt = '0;
    return t;
  endfunction

  // ----------------------------------------
  // per-axis output forming
  // ----------------------------------------
  assign rate_a[0] = AXIS_RATE_X;
  assign rate_a[1] = AXIS_RATE_Y;
  assign rate_a[2] = AXIS_RATE_Z;

  for (genvar a = 0; a < AXES; a++) begin : g_axis
    gos_axis u_axis (
      .clk       (SYS_CLK),
      .rst_b     (RST_B),
      .tick      (s_r.tick),
      .clr       (acc_clr),
      .integ_clr (integ_clr),
      .omode     (gos_omode_t'(CFG_OUT_MODE)),
      .rate      (rate_a[a]),
      .value     (val_a[a])
    );
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    push_v = 1'b0;
    acc_clr = 1'b0;
    integ_clr = 1'b0;
    push_dg.kind = DK_MEAS;
    push_dg.startup = s_r.startup;
    push_dg.x = val_a[0];
    push_dg.y = val_a[1];
    push_dg.z = val_a[2];
    // pins cross in through two flops; edge taken after the second
    s_nxt.rst_s1 = EXTERNAL_RESET_LOW;
    s_nxt.rst_s2 = s_r.rst_s1;
    s_nxt.trg_s1 = TRIGGER_INPUT;
    s_nxt.trg_s2 = s_r.trg_s1;
    s_nxt.trg_d = s_r.trg_s2;
    trig_fall = s_r.trg_d && !s_r.trg_s2;
    // internal sample tick, never gated by mode
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == TCNT_W'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1; // R9 R12
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end
    // n of zero is taken as one sample per transmission
    n_m1 = (CFG_SAMPLES_PER_TX == '0) ? '0 : CFG_SAMPLES_PER_TX - 1'b1;
    rate_tick = s_r.tick && (s_r.div_cnt >= n_m1);
    if (s_r.tick) begin
      s_nxt.div_cnt = rate_tick ? '0 : s_r.div_cnt + 1'b1;
    end
    ext_sync = (s_r.mode == MD_NORMAL) && CFG_EXT_TRIG;

    case (s_r.mode)
      MD_INIT: begin
        acc_clr = 1'b1;
        integ_clr = 1'b1;
        if (!s_r.settled) begin
          if (s_r.tick) begin
            if (s_r.phase_cnt == PCNT_W'(SETTLE_TICKS_P - 1)) begin
              s_nxt.settled = 1'b1; // R5
              s_nxt.phase_cnt = '0;
            end else begin
              s_nxt.phase_cnt = s_r.phase_cnt + 1'b1;
            end
          end
        end else if (!s_r.id_wait) begin
          // identity datagrams go out regardless of trigger mode
          push_v = 1'b1;
          push_dg.startup = 1'b0;
          push_dg.kind = gos_kind_t'(s_r.id_idx + 2'h1); // R5 R6
          if (push_if.ready) begin
            s_nxt.id_wait = 1'b1;
          end
        end else if (TX_DONE) begin
          s_nxt.id_wait = 1'b0;
          if (s_r.id_idx == 2'(ID_LAST)) begin
            s_nxt.mode = MD_NORMAL; // R7
            s_nxt.startup = 1'b1; // R11
            s_nxt.phase_cnt = '0;
            s_nxt.div_cnt = '0;
          end else begin
            s_nxt.id_idx = s_r.id_idx + 2'h1;
          end
        end
      end
      MD_NORMAL: begin
        if (s_r.startup && s_r.tick) begin
          if (s_r.phase_cnt == PCNT_W'(STARTUP_TICKS_P - 1)) begin
            s_nxt.startup = 1'b0; // R11
          end else begin
            s_nxt.phase_cnt = s_r.phase_cnt + 1'b1;
          end
        end
        // no status or start-up term gates the send
        if (s_r.send_pend) begin
          push_v = 1'b1; // R10 R12
          if (s_r.id_pend) begin
            push_dg.kind = s_r.id_kind; // R8
          end
          if (push_if.ready) begin
            s_nxt.send_pend = 1'b0;
            s_nxt.id_pend = 1'b0;
            acc_clr = !s_r.id_pend; // R19
          end
        end
        // a new send request after the clear, so one in the send cycle is not lost
        if (CFG_EXT_TRIG ? trig_fall : rate_tick) begin
          s_nxt.send_pend = 1'b1; // R9 R20
        end
        // last request before the send wins
        if (CMD_ID_REQ) begin
          s_nxt.id_pend = 1'b1; // R8
          s_nxt.id_kind = gos_kind_t'(CMD_ID_KIND);
        end
        if (CMD_SVC_ENTER) begin
          s_nxt.mode = MD_SERVICE;
          s_nxt.send_pend = 1'b0;
        end
        if (CMD_RESET) begin
          s_nxt = go_init(s_nxt); // R4
        end
      end
      MD_SERVICE: begin
        if (CMD_SVC_EXIT) begin
          if (CMD_SVC_TO_INIT) begin
            s_nxt = go_init(s_nxt); // R4
          end else begin
            s_nxt.mode = MD_NORMAL;
            s_nxt.startup = 1'b0; // R13
            s_nxt.div_cnt = '0;
          end
        end
      end
      default: begin
        s_nxt = go_init(s_nxt);
      end
    endcase

    // pin reset holds the sequencer in init for as long as it is low
    if (!s_r.rst_s2) begin
      s_nxt = go_init(s_nxt); // R4 R21
    end

    // ----------------------------------------
    // validity strobe
    // ----------------------------------------
    pushed = push_v && push_if.ready;
    done = TX_DONE && (s_r.out_cnt != 2'h0);
    s_nxt.out_cnt = s_r.out_cnt + {1'b0, pushed} - {1'b0, done};
    if (ext_sync) begin
      // sync only: low for half a sample period per rate tick, so that
      // one sample per send still shows a falling edge every tick
      if (rate_tick) begin
        s_nxt.validity_strobe = 1'b0; // R1 R3
      end else if (s_r.tick_cnt == TCNT_W'(TICK_CYCLES / 2)) begin
        s_nxt.validity_strobe = 1'b1; // R3
      end
    end else begin
      if (pushed) begin
        s_nxt.validity_strobe = 1'b0; // R1
      end else if (done && s_r.out_cnt == 2'h1) begin
        s_nxt.validity_strobe = 1'b1; // R2
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // buffering towards the transmitter
  // ----------------------------------------
  assign push_if.valid = push_v;
  assign push_if.dg    = push_dg;
  assign pop_if.ready  = DG_READY;

  gos_buf u_buf (
    .clk    (SYS_CLK),
    .rst_b  (RST_B),
    .in_if  (push_if),
    .out_if (pop_if)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign DG_VALID        = pop_if.valid;
  assign DG_KIND         = pop_if.dg.kind;
  assign DG_STARTUP      = pop_if.dg.startup;
  assign DG_X            = pop_if.dg.x;
  assign DG_Y            = pop_if.dg.y;
  assign DG_Z            = pop_if.dg.z;
  assign VALIDITY_STROBE = s_r.validity_strobe;
  assign STATUS_STARTUP  = s_r.startup;
  assign OP_MODE         = s_r.mode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_last_id_sent;
    s_r.mode == MD_INIT && s_r.id_wait && TX_DONE && s_r.id_idx == 2'h2 && s_r.rst_s2;
  endsequence

  sequence s_normal_started;
    s_r.mode == MD_NORMAL && STATUS_STARTUP && s_r.phase_cnt == '0;
  endsequence

  sequence s_normal_quiet;
    s_r.mode == MD_NORMAL && s_r.rst_s2 && !CMD_RESET && !CMD_SVC_ENTER;
  endsequence

  a_init_to_normal: assert property ( // R7
    s_last_id_sent |=> s_normal_started)
    else $error("init did not hand over to normal with start-up set");

  a_tov_push_low: assert property ( // R1
    pushed && !ext_sync |=> !VALIDITY_STROBE)
    else $error("strobe not low after datagram launch");

  a_tov_rise_done: assert property ( // R2
    $rose(VALIDITY_STROBE) && !$past(ext_sync) |-> $past(TX_DONE) && s_r.out_cnt == 2'h0)
    else $error("strobe rose before last bit left");

  a_ext_sync_low: assert property ( // R3
    ext_sync && rate_tick |=> !VALIDITY_STROBE ##1 !VALIDITY_STROBE)
    else $error("sync strobe not low after rate tick");

  a_reset_init: assert property ( // R4
    !s_r.rst_s2 |=> s_r.mode == MD_INIT && !STATUS_STARTUP && !s_r.settled)
    else $error("pin reset did not force init");

  a_id_launch: assert property ( // R5
    s_r.mode == MD_INIT && s_r.rst_s2 && pushed |-> push_dg.kind != DK_MEAS ##1 s_r.id_wait)
    else $error("init launched a measurement datagram");

  a_startup_end: assert property ( // R11
    s_normal_quiet ##0 (STATUS_STARTUP && s_r.tick
      && s_r.phase_cnt == PCNT_W'(STARTUP_TICKS_P - 1)) |=> !STATUS_STARTUP)
    else $error("start-up bit not cleared at end of period");

  a_svc_skip: assert property ( // R13
    s_r.mode == MD_SERVICE && CMD_SVC_EXIT && !CMD_SVC_TO_INIT && s_r.rst_s2
      |=> s_r.mode == MD_NORMAL && !STATUS_STARTUP)
    else $error("service exit to normal ran a start-up");

  a_trig_send: assert property ( // R20
    s_normal_quiet ##0 (CFG_EXT_TRIG && trig_fall) |=> s_r.send_pend)
    else $error("trigger edge did not request a send");

  a_send_held: assert property ( // R10
    s_normal_quiet ##0 (s_r.send_pend && !push_if.ready) |=> s_r.send_pend)
    else $error("stalled send was dropped");
endmodule
`default_nettype wire

// >>> verification/gos_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module gos_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // cycles one datagram spends on the wire, at least 1
  input  wire logic [7:0] tx_cycles,
  // datagram handshake
  input  wire logic       dg_valid,
  output logic            dg_ready,
  output logic            tx_done
);
  // ----------------------------------------
  // serialiser stand-in
  // ----------------------------------------
  logic       took_r;
  logic [7:0] cnt_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      took_r <= 1'b0;
    end else begin
      took_r <= dg_valid && dg_ready;
    end
  end

  // one word on the wire at a time; words are taken whatever their status
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dg_ready <= 1'b1;
      tx_done  <= 1'b0;
      cnt_r    <= 8'h00;
    end else begin
      tx_done <= 1'b0;
      if (took_r) begin
        dg_ready <= 1'b0;
        cnt_r    <= tx_cycles;
      end else if (cnt_r == 8'h01) begin
        tx_done  <= 1'b1;
        dg_ready <= 1'b1;
        cnt_r    <= 8'h00;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/gyro_output_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module gyro_output_sequencer_test;
  import gos_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              SYS_CLK, RST_B, EXTERNAL_RESET_LOW, TRIGGER_INPUT, VALIDITY_STROBE;
  logic              CFG_EXT_TRIG, CMD_RESET, CMD_ID_REQ, CMD_SVC_ENTER, CMD_SVC_EXIT, CMD_SVC_TO_INIT;
  logic [1:0]        CFG_OUT_MODE, CMD_ID_KIND, DG_KIND, OP_MODE;
  logic [DIV_W-1:0]  CFG_SAMPLES_PER_TX;
  logic [RATE_W-1:0] AXIS_RATE_X, AXIS_RATE_Y, AXIS_RATE_Z, DG_X, DG_Y, DG_Z, g_x, g_y, g_z, d;
  logic              DG_VALID, DG_READY, DG_STARTUP, TX_DONE, STATUS_STARTUP, got, g_st, g_tov;
  logic [1:0]        g_kind;
  logic [7:0]        tx_cycles;
  int                fails, n_compared;

  // short counts keep the run brief; expectations use these values
  gos_top #(.TICK_CYCLES(20), .SETTLE_TICKS_P(2), .STARTUP_TICKS_P(3)) gos_top_inst (
    .SYS_CLK, .RST_B, .EXTERNAL_RESET_LOW, .TRIGGER_INPUT, .VALIDITY_STROBE, .CFG_EXT_TRIG,
    .CFG_OUT_MODE, .CFG_SAMPLES_PER_TX, .CMD_RESET, .CMD_ID_REQ, .CMD_ID_KIND, .CMD_SVC_ENTER,
    .CMD_SVC_EXIT, .CMD_SVC_TO_INIT, .AXIS_RATE_X, .AXIS_RATE_Y, .AXIS_RATE_Z, .DG_VALID, .DG_READY,
    .DG_KIND, .DG_STARTUP, .DG_X, .DG_Y, .DG_Z, .TX_DONE, .STATUS_STARTUP, .OP_MODE);

  gos_host_model gos_host_model_inst (
    .clk(SYS_CLK), .rst_b(RST_B), .tx_cycles(tx_cycles), .dg_valid(DG_VALID), .dg_ready(DG_READY),
    .tx_done(TX_DONE));

  always #20 SYS_CLK = ~SYS_CLK;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // waits a bounded number of edges for a taken datagram and captures it
  task automatic get_dg(input int lim);
    int i;
    got = 1'b0;
    for (i = 0; i < lim && !got; i++) begin
      // look well before the edge, where handshake and word have settled
      @(negedge SYS_CLK);
      #1;
      if (DG_VALID === 1'b1 && DG_READY === 1'b1) begin
        got = 1'b1;
        {g_kind, g_st, g_tov, g_x, g_y, g_z} = {DG_KIND, DG_STARTUP, VALIDITY_STROBE, DG_X, DG_Y, DG_Z};
      end
      @(posedge SYS_CLK);
    end
  endtask

  task automatic svc(input logic to_init);
    @(negedge SYS_CLK) CMD_SVC_ENTER = 1'b1;
    @(negedge SYS_CLK) CMD_SVC_ENTER = 1'b0;
    repeat (4) @(negedge SYS_CLK);
    chk(OP_MODE === 2'h2, "service not entered");
    CMD_SVC_TO_INIT = to_init;
    CMD_SVC_EXIT = 1'b1;
    @(negedge SYS_CLK) CMD_SVC_EXIT = 1'b0;
    repeat (4) @(negedge SYS_CLK);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init;
    int k;
    for (k = 1; k <= 3; k++) begin
      get_dg(300);
      chk(got && g_kind === k[1:0], "identity datagram order");
    end
    repeat (10) @(negedge SYS_CLK);
    chk(OP_MODE === 2'h1 && STATUS_STARTUP === 1'b1, "normal with start-up");
    get_dg(40);
    chk(got && g_kind === 2'h0 && g_st === 1'b1, "start-up measurement");
    repeat (80) @(negedge SYS_CLK);
    chk(STATUS_STARTUP === 1'b0, "start-up not over");
  endtask

  task automatic t_rate;
    int i;
    get_dg(40);
    chk(got && g_x === 24'hFFF000 && g_y === 24'h001234 && g_z === 24'h7FFFFF, "rate value");
    chk(g_tov === 1'b0, "strobe high at send");
    for (i = 0; i < 20 && TX_DONE !== 1'b1; i++) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk(VALIDITY_STROBE === 1'b1, "strobe low after last bit");
    tx_cycles = 8'h2D;
    // slow wire: sends outpace it, so the buffer fills and words queue
    for (i = 0; i < 4; i++) begin
      get_dg(100);
      chk(got && g_kind === 2'h0 && g_tov === 1'b0, "stalled send");
    end
    tx_cycles = 8'h03;
    repeat (200) @(negedge SYS_CLK);
  endtask

  task automatic t_modes;
    @(negedge SYS_CLK);
    AXIS_RATE_X = 24'h0003E8;
    CFG_SAMPLES_PER_TX = 12'h002;
    CFG_OUT_MODE = OM_INCR;
    get_dg(100);
    get_dg(100);
    chk(got && g_x === 24'h000080, "incremental angle");
    @(negedge SYS_CLK) CFG_OUT_MODE = OM_AVG;
    get_dg(100);
    get_dg(100);
    chk(got && g_x === 24'h0003E8, "average rate");
    @(negedge SYS_CLK) CFG_OUT_MODE = OM_INTEG;
    get_dg(100);
    d = g_x;
    get_dg(100);
    chk(got && g_x - d === 24'h000080, "integrated step");
    @(negedge SYS_CLK) CFG_OUT_MODE = OM_RATE;
    CFG_SAMPLES_PER_TX = 12'h001;
  endtask

  task automatic t_idreq;
    int k;
    for (k = 1; k <= 3; k++) begin
      get_dg(40);
      @(negedge SYS_CLK) CMD_ID_KIND = k[1:0];
      CMD_ID_REQ = 1'b1;
      @(negedge SYS_CLK) CMD_ID_REQ = 1'b0;
      get_dg(40);
      chk(got && g_kind === k[1:0], "requested identity");
      get_dg(40);
      chk(got && g_kind === 2'h0, "measurement after identity");
    end
  endtask

  task automatic t_trig;
    get_dg(40);
    @(negedge SYS_CLK) CFG_EXT_TRIG = 1'b1;
    repeat (10) @(negedge SYS_CLK);
    get_dg(60);
    chk(!got, "send without trigger");
    @(negedge SYS_CLK) TRIGGER_INPUT = 1'b0;
    get_dg(20);
    chk(got && g_kind === 2'h0 && g_x === 24'h0003E8, "triggered send");
    @(negedge SYS_CLK) TRIGGER_INPUT = 1'b1;
    CFG_EXT_TRIG = 1'b0;
  endtask

  task automatic t_service;
    int k;
    svc(1'b0);
    chk(OP_MODE === 2'h1 && STATUS_STARTUP === 1'b0, "service exit to normal");
    get_dg(40);
    chk(got && g_st === 1'b0, "start-up flag after service");
    svc(1'b1);
    chk(OP_MODE === 2'h0, "service exit to init");
    for (k = 1; k <= 3; k++) get_dg(300);
    repeat (10) @(negedge SYS_CLK);
    // service entered while start-up still runs, so the skip is visible
    chk(got && g_kind === 2'h3 && STATUS_STARTUP === 1'b1, "start-up before service");
    svc(1'b0);
    chk(OP_MODE === 2'h1 && STATUS_STARTUP === 1'b0, "start-up kept after service");
  endtask

  task automatic t_resets;
    get_dg(40);
    @(negedge SYS_CLK) CMD_RESET = 1'b1;
    @(negedge SYS_CLK) CMD_RESET = 1'b0;
    t_init();
    get_dg(40);
    @(negedge SYS_CLK) EXTERNAL_RESET_LOW = 1'b0;
    repeat (5) @(negedge SYS_CLK);
    chk(OP_MODE === 2'h0, "pin reset");
    EXTERNAL_RESET_LOW = 1'b1;
    t_init();
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {SYS_CLK, RST_B, CFG_EXT_TRIG, CMD_RESET, CMD_ID_REQ, CMD_SVC_ENTER, CMD_SVC_EXIT} = 7'h00;
    {EXTERNAL_RESET_LOW, TRIGGER_INPUT, CMD_SVC_TO_INIT, CMD_ID_KIND} = 5'h18;
    {fails, n_compared} = 0;
    tx_cycles = 8'h03;
    CFG_OUT_MODE = OM_RATE;
    CFG_SAMPLES_PER_TX = 12'h001;
    {AXIS_RATE_X, AXIS_RATE_Y, AXIS_RATE_Z} = {24'hFFF000, 24'h001234, 24'h7FFFFF};
    repeat (2) @(posedge SYS_CLK);
    chk(OP_MODE === 2'h0 && VALIDITY_STROBE === 1'b1 && DG_VALID === 1'b0, "reset state");
    @(negedge SYS_CLK) RST_B = 1'b1;
    t_init();
    t_rate();
    t_modes();
    t_idreq();
    t_trig();
    t_service();
    t_resets();
    tally_and_finish();
  end

  initial begin
    repeat (30000) @(posedge SYS_CLK);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
